/* File: hw/urb_pkg.sv */
package urb_pkg;
  // Register addresses on the 3-bit host bus
  localparam logic [2:0] ADDR_0      = 3'h0;
  localparam logic [2:0] ADDR_1      = 3'h1;
  localparam logic [2:0] ADDR_2      = 3'h2;
  localparam logic [2:0] ADDR_LINE   = 3'h3;
  localparam logic [2:0] ADDR_LSTATE = 3'h5;
  // Line control value that opens the enhanced bank
  localparam logic [7:0] LCTL_ENH    = 8'hBF;
  localparam int         LCTL_DIV    = 7;
  localparam int         EXT_UNLOCK  = 4;
  // Mask bit positions
  localparam int         MASK_RXD    = 0;
  localparam int         MASK_TXE    = 1;
  localparam int         MASK_LINE   = 2;
  localparam int         MASK_MODEM  = 3;
  // Fifo setup bits
  localparam int         SETUP_EN    = 0;
  localparam int         SETUP_CLR   = 1;
  // Interrupt source codes, bits 5:0
  localparam logic [5:0] SRC_NONE    = 6'h01;
  localparam logic [5:0] SRC_LINE    = 6'h06;
  localparam logic [5:0] SRC_TIMEOUT = 6'h0C;
  localparam logic [5:0] SRC_RXLVL   = 6'h04;
  localparam logic [5:0] SRC_TXREADY = 6'h02;
  localparam logic [5:0] SRC_MODEM   = 6'h00;
  // Receive time-out: four characters plus extra bits
  localparam int         CHAR_BITS   = 10;
  localparam int         TO_CHARS    = 4;
  localparam int         TO_EXTRA    = 12;
  localparam int         TO_BITS     = TO_CHARS * CHAR_BITS + TO_EXTRA;
  localparam int         SAMPLES     = 16;
  // Values after reset
  localparam logic [7:0] RST_REG     = 8'h00;
endpackage : urb_pkg

/* File: hw/urb_regs.sv */
`timescale 1ns/1ps
// Operation
// - divisor low, high, fraction at 0..2 only when line control bit 7 set; none at 0xBF, fraction also needs extended feature bit 4.
// - interrupt mask is read/write and gates rx data, tx empty, line, modem sources.
// - the highest-priority permitted source is reported in the interrupt source register.
// - with fifos and rx mask on, raise rx data interrupt at trigger fill level.
// - drop rx data interrupt as soon as fill falls below trigger level.
// - source bit 2 shows rx trigger, bits 2 and 3 time-out, clearing with the interrupt.
// - data-ready sets in the cycle a character enters the receive fifo.
// - data-ready returns to zero only when the receive fifo is empty.
// - receive holding is read-only; writes at that address go to transmit holding.
// - raise receive time-out after four character times plus 12 bit times unread.
// - source bit 0 reads one with nothing pending, zero while any pending.
module urb_regs #(
  parameter int         DEPTH   = 64,
  parameter logic [7:0] DEV_REV = 8'h01,  // Arbitrary value
  parameter logic [7:0] DEV_ID  = 8'h5A   // Arbitrary value
) (
  // Clock and reset
  input  wire  logic        clk_sys,
  input  wire  logic        rst_n,
  // Host register bus
  input  wire  logic [2:0]  addr,
  input  wire  logic        rdStb,
  input  wire  logic        wrStb,
  input  wire  logic [7:0]  wrData,
  output logic       [7:0]  rdData,
  // Receive characters from the shift register
  input  wire  logic        rxValid,
  input  wire  logic [7:0]  rxChar,
  output logic              rxReady,
  // Transmit holding writes
  output logic              txStb,
  output logic       [7:0]  txData,
  // Status from other parts of the core
  input  wire  logic        txEmpty,
  input  wire  logic        lineErr,
  input  wire  logic        modemChg,
  // Baud generator settings and interrupt line
  output logic       [15:0] divisor,
  output logic       [7:0]  divFrac,
  output logic              intReq
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [7:0]                lineCtl;
    logic [7:0]                mask;
    logic                      fifoEn;
    logic [7:0]                divLo;
    logic [7:0]                divHi;
    logic [7:0]                divFr;
    logic [7:0]                featCtl;
    logic [7:0]                extFeat;
    logic [7:0]                threshold;
    logic [3:0][7:0]           flowChr;
    logic [DEPTH-1:0][7:0]     mem;
    logic [AW-1:0]             wp;
    logic [AW-1:0]             rp;
    logic [AW:0]               cnt;
    logic [1:0][7:0]           buff;
    logic [1:0]                bufCnt;
    logic                      dataRdy;
    logic                      txPend;
    logic                      txEmptyQ;
    logic [19:0]               bitCyc;
    logic [5:0]                bitsSeen;
    logic                      toFlag;
    logic [7:0]                rdData;
    logic [7:0]                txData;
    logic                      txStb;
    logic                      rxReady;
    logic                      intReq;
  } urb_state_s;

  urb_state_s s_r;
  urb_state_s s_nxt;

  logic        enh;
  logic        dlab;
  logic        divZero;
  logic        pop;
  logic        push;
  logic        acc;
  logic        fifoClr;
  logic [AW:0] lvl;
  logic        rxAtLvl;
  logic [5:0]  srcCode;
  logic [7:0]  srcVal;
  logic [7:0]  stateVal;
  logic [7:0]  rdv;
  logic [19:0] bitLen;
  logic [1:0]  slot;

  always_comb begin
    s_nxt   = s_r;
    s_nxt.txStb = 1'b0;
    enh     = (s_r.lineCtl == urb_pkg::LCTL_ENH);
    dlab    = s_r.lineCtl[urb_pkg::LCTL_DIV];
    divZero = ({s_r.divHi, s_r.divLo} == 16'h0000);
    fifoClr = 1'b0;
    // Trigger: one character in non-fifo mode or with level zero, programmed level otherwise
    if (!s_r.fifoEn || s_r.threshold == 8'h00) begin
      lvl = (AW+1)'(1);
    end else begin
      lvl = (AW+1)'(s_r.threshold);
    end
    rxAtLvl = s_r.mask[urb_pkg::MASK_RXD] && (s_r.cnt >= lvl);
    // Priority encoding of permitted sources
    if (s_r.mask[urb_pkg::MASK_LINE] && lineErr) begin
      srcCode = urb_pkg::SRC_LINE;
    end else if (s_r.mask[urb_pkg::MASK_RXD] && s_r.toFlag) begin
      srcCode = urb_pkg::SRC_TIMEOUT;
    end else if (rxAtLvl) begin
      srcCode = urb_pkg::SRC_RXLVL;
    end else if (s_r.mask[urb_pkg::MASK_TXE] && s_r.txPend) begin
      srcCode = urb_pkg::SRC_TXREADY;
    end else if (s_r.mask[urb_pkg::MASK_MODEM] && modemChg) begin
      srcCode = urb_pkg::SRC_MODEM;
    end else begin
      srcCode = urb_pkg::SRC_NONE;
    end
    srcVal   = {{2{s_r.fifoEn}}, srcCode};
    stateVal = {1'b0, txEmpty && !s_r.txStb, txEmpty, 4'h0, s_r.dataRdy};
    s_nxt.intReq = (srcCode != urb_pkg::SRC_NONE);
    // Read decode
    pop = 1'b0;
    rdv = urb_pkg::RST_REG;
    case (addr)
      urb_pkg::ADDR_0: begin
        if (enh) begin
          rdv = 8'(s_r.cnt);
        end else if (dlab) begin
          rdv = divZero ? DEV_REV : s_r.divLo;
        end else begin
          rdv = s_r.mem[s_r.rp];
          pop = rdStb && s_r.cnt != '0;
        end
      end
      urb_pkg::ADDR_1: begin
        if (enh) begin
          rdv = s_r.featCtl;
        end else if (dlab) begin
          rdv = divZero ? DEV_ID : s_r.divHi;
        end else begin
          rdv = s_r.mask;
        end
      end
      urb_pkg::ADDR_2: begin
        if (enh) begin
          rdv = s_r.extFeat;
        end else if (dlab && s_r.extFeat[urb_pkg::EXT_UNLOCK]) begin
          rdv = s_r.divFr;
        end else begin
          rdv = srcVal;
        end
      end
      urb_pkg::ADDR_LINE: rdv = s_r.lineCtl;
      default: begin
        if (enh) begin
          rdv = s_r.flowChr[addr[1:0]];
        end else if (addr == urb_pkg::ADDR_LSTATE) begin
          rdv = stateVal;
        end else begin
          rdv = urb_pkg::RST_REG;
        end
      end
    endcase
    if (rdStb) begin
      s_nxt.rdData = rdv;
    end
    // Write decode
    if (wrStb) begin
      case (addr)
        urb_pkg::ADDR_0: begin
          if (enh) begin
            s_nxt.threshold = wrData;
          end else if (dlab) begin
            s_nxt.divLo = wrData;
          end else begin
            s_nxt.txData = wrData;
            s_nxt.txStb  = 1'b1;
          end
        end
        urb_pkg::ADDR_1: begin
          if (enh) begin
            s_nxt.featCtl = wrData;
          end else if (dlab) begin
            s_nxt.divHi = wrData;
          end else if (s_r.extFeat[urb_pkg::EXT_UNLOCK]) begin
            s_nxt.mask = wrData;
          end else begin
            s_nxt.mask = {s_r.mask[7:4], wrData[3:0]};
          end
        end
        urb_pkg::ADDR_2: begin
          if (enh) begin
            s_nxt.extFeat = wrData;
          end else if (dlab) begin
            if (s_r.extFeat[urb_pkg::EXT_UNLOCK]) begin
              s_nxt.divFr = wrData;
            end
          end else begin
            s_nxt.fifoEn = wrData[urb_pkg::SETUP_EN];
            fifoClr      = wrData[urb_pkg::SETUP_CLR];
          end
        end
        urb_pkg::ADDR_LINE: s_nxt.lineCtl = wrData;
        default: begin
          if (enh) begin
            s_nxt.flowChr[addr[1:0]] = wrData;
          end
        end
      endcase
    end
    // Two-entry buffer ahead of the receive fifo
    acc  = rxValid && s_r.rxReady;
    push = (s_r.bufCnt != 2'd0) && (s_r.cnt < (AW+1)'(DEPTH)) && !fifoClr;
    if (push) begin
      s_nxt.buff[0] = s_r.buff[1];
    end
    slot = s_r.bufCnt - {1'b0, push};
    if (acc) begin
      s_nxt.buff[slot[0]] = rxChar;
    end
    s_nxt.bufCnt  = slot + {1'b0, acc};
    s_nxt.rxReady = (s_nxt.bufCnt != 2'd2);
    // Receive fifo
    if (fifoClr) begin
      s_nxt.wp  = '0;
      s_nxt.rp  = '0;
      s_nxt.cnt = '0;
    end else begin
      if (push) begin
        s_nxt.mem[s_r.wp] = s_r.buff[0];
        s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
        s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    s_nxt.dataRdy = push || (s_nxt.cnt != '0);
    // Transmit-ready event: set wins over clear
    s_nxt.txEmptyQ = txEmpty;
    if ((rdStb && addr == urb_pkg::ADDR_2 && !enh && !(dlab && s_r.extFeat[urb_pkg::EXT_UNLOCK]))
        || s_nxt.txStb) begin
      s_nxt.txPend = 1'b0;
    end
    if (txEmpty && (!s_r.txEmptyQ || (s_nxt.mask[urb_pkg::MASK_TXE] &&
        !s_r.mask[urb_pkg::MASK_TXE]))) begin
      s_nxt.txPend = 1'b1;
    end
    // Receive time-out timer, restarted by fifo activity
    bitLen = divZero ? 20'(urb_pkg::SAMPLES) : 20'({s_r.divHi, s_r.divLo}) * 20'(urb_pkg::SAMPLES);
    if (pop || push || s_r.cnt == '0 || fifoClr) begin
      s_nxt.bitCyc   = '0;
      s_nxt.bitsSeen = '0;
      if (pop || s_nxt.cnt == '0) begin
        s_nxt.toFlag = 1'b0;
      end
    end else if (s_r.bitsSeen == 6'(urb_pkg::TO_BITS)) begin
      s_nxt.toFlag = 1'b1;
    end else if (s_r.bitCyc == bitLen - 20'd1) begin
      s_nxt.bitCyc   = '0;
      s_nxt.bitsSeen = s_r.bitsSeen + 6'd1;
    end else begin
      s_nxt.bitCyc = s_r.bitCyc + 20'd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.rxReady <= 1'b1;
      s_r.txEmptyQ <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdData  = s_r.rdData;
  assign rxReady = s_r.rxReady;
  assign txStb   = s_r.txStb;
  assign txData  = s_r.txData;
  assign divisor = {s_r.divHi, s_r.divLo};
  assign divFrac = s_r.divFr;
  assign intReq  = s_r.intReq;
endmodule : urb_regs

/* File: dv/urb_regs_assertions.sv */
`timescale 1ns/1ps
module urb_regs_assertions (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Host bus
  input wire logic [2:0]  addr,
  input wire logic        rdStb,
  input wire logic        wrStb,
  input wire logic [7:0]  wrData,
  input wire logic [7:0]  rdData,
  // Outputs
  input wire logic        txStb,
  input wire logic [7:0]  txData,
  input wire logic [15:0] divisor,
  input wire logic [7:0]  divFrac,
  input wire logic        intReq
);
  logic [7:0] lineCtl_r;
  logic [3:0] mask_r;
  logic       unlock_r;
  logic       divWr_r;
  logic       fracWr_r;
  logic       txWr_r;
  logic       dlab;
  logic       enh;
  assign dlab = lineCtl_r[7];
  assign enh  = lineCtl_r == 8'hBF;
  // Shadow of line control, mask and unlock bit; kind of write in the last cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lineCtl_r <= 8'h00;
      mask_r    <= 4'h0;
      unlock_r  <= 1'b0;
      divWr_r   <= 1'b0;
      fracWr_r  <= 1'b0;
      txWr_r    <= 1'b0;
    end else begin
      divWr_r  <= wrStb && dlab && !enh && addr[2:1] == 2'h0;
      fracWr_r <= wrStb && addr == 3'h2 && dlab && !enh && unlock_r;
      txWr_r   <= wrStb && addr == 3'h0 && !dlab;
      if (wrStb) begin
        if (addr == 3'h3) lineCtl_r <= wrData;
        if (addr == 3'h1 && !dlab) mask_r <= wrData[3:0];
        if (addr == 3'h2 && enh) unlock_r <= wrData[4];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  lcr_read_a: assert property (rdStb && addr == 3'h3 |=> rdData == lineCtl_r)
    else $error("line control readback wrong");
  div_low_a: assert property (wrStb && addr == 3'h0 && dlab && !enh
    |=> divisor[7:0] == $past(wrData)) else $error("divisor low not written");
  div_hold_a: assert property ($changed(divisor)
    |-> divWr_r) else $error("divisor changed");
  frac_a: assert property ($changed(divFrac)
    |-> fracWr_r) else $error("fraction changed");
  tx_write_a: assert property (wrStb && addr == 3'h0 && !dlab
    |=> txStb && txData == $past(wrData)) else $error("transmit write lost");
  tx_quiet_a: assert property (txStb |-> txWr_r)
    else $error("stray transmit strobe");
  mask_read_a: assert property (rdStb && addr == 3'h1 && !dlab
    |=> rdData[3:0] == mask_r) else $error("mask readback wrong");
  mask_gate_a: assert property (mask_r == 4'h0 [*2] |-> !intReq)
    else $error("interrupt while masked");
  cover property (txStb);
  cover property (intReq);
  cover property ($changed(divFrac));
endmodule : urb_regs_assertions

bind urb_regs urb_regs_assertions urb_regs_assertions_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .addr(addr), .rdStb(rdStb), .wrStb(wrStb), .wrData(wrData), .rdData(rdData),
  .txStb(txStb), .txData(txData), .divisor(divisor), .divFrac(divFrac), .intReq(intReq));

/* File: dv/urb_host.sv */
`timescale 1ns/1ps
module urb_host (
  // Clock
  input  wire logic       clk_sys,
  // Register bus
  output logic      [2:0] addr,
  output logic            rdStb,
  output logic            wrStb,
  output logic      [7:0] wrData,
  input  wire logic [7:0] rdData,
  // Receive stream
  output logic            rxValid,
  output logic      [7:0] rxChar,
  input  wire logic       rxReady
);
  initial begin
    {addr, rdStb, wrStb, wrData, rxValid, rxChar} = '0;
  end
  // Write strobe for one cycle, then spoil the data lines
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    {addr, wrData, wrStb} = {a, v, 1'b1};
    @(negedge clk_sys);
    {wrData, wrStb} = {~v, 1'b0};
  endtask : wr
  // Read data is registered at the taking edge
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    {addr, rdStb} = {a, 1'b1};
    @(negedge clk_sys);
    rdStb = 1'b0;
    v = rdData;
  endtask : rd
  // Character held until taken
  task automatic push(input logic [7:0] c);
    @(negedge clk_sys);
    {rxChar, rxValid} = {c, 1'b1};
    do @(posedge clk_sys); while (!rxReady);
    @(negedge clk_sys);
    {rxChar, rxValid} = {~c, 1'b0};
  endtask : push
endmodule : urb_host

/* File: dv/urb_regs_test.sv */
`timescale 1ns/1ps
module urb_regs_test;
  localparam logic [7:0] REV = 8'h3C;  // Arbitrary value
  localparam logic [7:0] ID  = 8'h71;  // Arbitrary value
  logic clk_sys, rst_n, rdStb, wrStb, rxValid, rxReady, txStb;
  logic txEmpty, lineErr, modemChg, intReq;
  logic [2:0]  addr;
  logic [7:0]  wrData, rdData, rxChar, txData, divFrac;
  logic [15:0] divisor;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] d;

  urb_regs #(.DEV_REV(REV), .DEV_ID(ID)) urb_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .addr(addr), .rdStb(rdStb), .wrStb(wrStb), .wrData(wrData), .rdData(rdData),
    .rxValid(rxValid), .rxChar(rxChar), .rxReady(rxReady), .txStb(txStb), .txData(txData),
    .txEmpty(txEmpty), .lineErr(lineErr), .modemChg(modemChg), .divisor(divisor),
    .divFrac(divFrac), .intReq(intReq));
  urb_host urb_host_inst (.clk_sys(clk_sys), .addr(addr), .rdStb(rdStb), .wrStb(wrStb),
    .wrData(wrData), .rdData(rdData), .rxValid(rxValid), .rxChar(rxChar), .rxReady(rxReady));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    urb_host_inst.rd(a, v);
    chk(v, exp);
  endtask : rchk

  task automatic t_div;
    rchk(3'h2, 8'h01);
    urb_host_inst.wr(3'h3, 8'h80);
    rchk(3'h0, REV);
    rchk(3'h1, ID);
    urb_host_inst.wr(3'h0, 8'h01);
    chk(divisor[7:0], 8'h01);
    urb_host_inst.wr(3'h2, 8'h35);
    chk(divFrac, 8'h00);
    rchk(3'h0, 8'h01);
    rchk(3'h1, 8'h00);
    urb_host_inst.wr(3'h3, 8'hBF);
    urb_host_inst.wr(3'h2, 8'h10);
    rchk(3'h2, 8'h10);
    urb_host_inst.wr(3'h0, 8'h02);
    urb_host_inst.wr(3'h3, 8'h80);
    urb_host_inst.wr(3'h2, 8'h35);
    chk(divFrac, 8'h35);
    $display("t_div done");
  endtask : t_div

  task automatic t_rx;
    urb_host_inst.wr(3'h3, 8'h03);
    urb_host_inst.wr(3'h2, 8'h01);
    urb_host_inst.wr(3'h1, 8'h01);
    chk({7'h0, rxReady}, 8'h01);
    urb_host_inst.push(8'h5C);
    repeat (2) @(negedge clk_sys);
    rchk(3'h5, 8'h61);
    chk({7'h0, intReq}, 8'h00);
    urb_host_inst.push(8'hA3);
    repeat (3) @(negedge clk_sys);
    chk({7'h0, intReq}, 8'h01);
    rchk(3'h2, 8'hC4);
    rchk(3'h0, 8'h5C);
    @(negedge clk_sys);
    chk({7'h0, intReq}, 8'h00);
    rchk(3'h2, 8'hC1);
    rchk(3'h5, 8'h61);
    rchk(3'h0, 8'hA3);
    rchk(3'h5, 8'h60);
    urb_host_inst.push(8'h7E);
    repeat (900) @(negedge clk_sys);
    rchk(3'h2, 8'hCC);
    rchk(3'h0, 8'h7E);
    rchk(3'h2, 8'hC1);
    $display("t_rx done");
  endtask : t_rx

  task automatic t_src;
    lineErr = 1'b1;
    urb_host_inst.wr(3'h1, 8'h04);
    @(negedge clk_sys);
    rchk(3'h2, 8'hC6);
    chk({7'h0, intReq}, 8'h01);
    lineErr = 1'b0;
    urb_host_inst.rd(3'h5, d);
    urb_host_inst.wr(3'h1, 8'h02);
    rchk(3'h2, 8'hC2);
    rchk(3'h2, 8'hC1);
    modemChg = 1'b1;
    urb_host_inst.wr(3'h1, 8'h08);
    rchk(3'h2, 8'hC0);
    urb_host_inst.wr(3'h0, 8'hA5);
    chk(txData, 8'hA5);
    $display("t_src done");
  endtask : t_src

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  initial begin
    {rst_n, lineErr, modemChg, txEmpty} = 4'h1;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    t_div();
    t_rx();
    t_src();
    end_of_test();
  end
endmodule : urb_regs_test
